// [logic/lart_timer.sv]
// Purpose: gap timer that holds off new L1 entry requests after a reject
// Assumes: request/accept/nak strobes are one-cycle pulses on clk
// Notes:   read data is valid the cycle after the read strobe only
//          requests inside a burst are absorbed, only the first is passed on
//          a gap of zero ends the gap after a single cycle
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - 14-bit gap, one count per 4 ns
// - gap resets to 0x947, software writable
// - request burst closes with accept or nak
// - after nak, count gap before new request
// - start select bit 16, reset one
// - select 0: early request restarts timer
// - select 1: early request ignored
// - after expiry next request starts fresh
module lart_timer
    import lart_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    // register port
    input  wire logic [lart_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [lart_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output var  logic [lart_pkg::DATA_W-1:0] reg_rdata,
    // link side events from the data link layer
    input  wire logic                        l1_req_rx,
    input  wire logic                        l1_accept_tx,
    input  wire logic                        l1_nak_tx,
    // request presented to the power manager
    output var  logic                        l1_req_seen,
    output var  logic                        gap_active
);
    import lart_pkg::*;

    // control register fields, both hold until the next write
    logic [GAP_W-1:0] min_request_gap_r;        // programmed gap in clk cycles
    logic             gap_timer_start_select_r; // 0 restart on request, 1 ignore
    // request tracking
    lart_state_t      state_r;                  // idle, burst pending or gap
    logic [GAP_W-1:0] cnt_r;                    // elapsed gap cycles
    // decodes
    logic             ctrl_wr;                  // control write decode
    logic             expire;                   // last gap cycle reached

    // full address match; aliases would let stray writes move the gap
    assign ctrl_wr = reg_wr && (reg_addr == GAP_CTRL_OFS);
    // count compared against gap-1 so the gap lasts exactly gap cycles;
    // the extra top bit keeps a gap of 0x3fff from wrapping the sum
    assign expire  = (state_r == LART_GAP) && ({1'b0, cnt_r} + 15'd1 >= {1'b0, min_request_gap_r});

    // control register fields
    // a write lands on the edge that samples the strobe; a new gap value
    // is used from the next timer cycle on, even in the middle of a gap
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // defaults: long gap, early requests ignored
            min_request_gap_r        <= GAP_RST;
            gap_timer_start_select_r <= START_SEL_RST;
        end else if (ctrl_wr) begin
            // bits 15:14 and 31:17 of the write are dropped here
            min_request_gap_r        <= reg_wdata[GAP_LSB +: GAP_W];
            gap_timer_start_select_r <= reg_wdata[START_SEL_BIT];
        end
    end

    // read mux, reserved bits stay zero
    // data stand for the one cycle after the strobe and are zero otherwise,
    // so an or-combined read bus upstream needs no extra gating
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            if (reg_addr == GAP_CTRL_OFS) begin
                reg_rdata[GAP_LSB +: GAP_W] <= min_request_gap_r;
                reg_rdata[START_SEL_BIT]    <= gap_timer_start_select_r;
            end else if (reg_addr == GAP_STAT_OFS) begin
                // status view: elapsed count and state, for debug
                reg_rdata[GAP_LSB +: GAP_W] <= cnt_r;
                reg_rdata[GAP_W +: 2]       <= state_r;
            end
        end else begin
            // no strobe: drop the last answer
            reg_rdata <= '0;
        end
    end

    // request tracking and gap timing
    // idle: waiting for the first dllp of a burst
    // pend: burst in progress, further dllps are part of it
    // gap:  reject answered, count before the next burst is recognised
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= LART_IDLE;
            cnt_r   <= '0;
        end else begin
            unique case (state_r)
                LART_IDLE: begin
                    // first request of a new burst
                    if (l1_req_rx) begin
                        state_r <= LART_PEND;
                    end
                end
                LART_PEND: begin
                    // dllps arriving here belong to the burst and change nothing
                    // burst ends with our answer; nak has priority
                    if (l1_nak_tx) begin
                        state_r <= LART_GAP;
                        cnt_r   <= '0;
                    end else if (l1_accept_tx) begin
                        // positive answer, no gap to enforce
                        state_r <= LART_IDLE;
                    end
                end
                LART_GAP: begin
                    // restart wins over expiry: a request in the last cycle
                    // still counts as early
                    if (!gap_timer_start_select_r && l1_req_rx) begin
                        cnt_r <= '0;
                    end else if (expire || min_request_gap_r == '0) begin
                        // gap over, clear the count for the next reject
                        state_r <= LART_IDLE;
                        cnt_r   <= '0;
                    end else begin
                        // select 1 lands here whatever the link sends
                        cnt_r <= cnt_r + 14'h0001;
                    end
                end
            endcase
        end
    end

    // registered outputs
    // both lag the state by one cycle; the power manager sees a new
    // request only once per burst and never while the gap runs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            l1_req_seen <= 1'b0;
            gap_active  <= 1'b0;
        end else begin
            // only the first dllp of a burst is passed on
            l1_req_seen <= l1_req_rx && (state_r == LART_IDLE);
            gap_active  <= (state_r == LART_GAP);
        end
    end

    // assertions
    // each one watches what this block drives; a few only restate simple
    // decodes but catch a mistyped state or field position early
    // the reset default check is the only one not disabled by reset
    a_gap_reset_val: assert property (@(posedge clk)
        $fell(sys_rst) |-> min_request_gap_r == GAP_RST && gap_timer_start_select_r)
        else $error("gap control not at reset value");
    a_req_blocked: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == LART_GAP |=> !l1_req_seen)
        else $error("request passed during gap");
    a_restart_clr: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == LART_GAP && !gap_timer_start_select_r && l1_req_rx |=> cnt_r == '0)
        else $error("early request did not restart timer");
    a_ignore_cnt: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == LART_GAP && gap_timer_start_select_r && !expire && min_request_gap_r != '0
        |=> cnt_r == $past(cnt_r) + 14'h0001)
        else $error("ignored request disturbed count");
    a_nak_starts: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == LART_PEND && l1_nak_tx |=> state_r == LART_GAP && cnt_r == '0)
        else $error("nak did not start gap");
    a_expire_free: assert property (@(posedge clk) disable iff (sys_rst)
        expire && !(l1_req_rx && !gap_timer_start_select_r) |=> state_r == LART_IDLE)
        else $error("gap did not end on expiry");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == GAP_CTRL_OFS |=> reg_rdata[15:14] == 2'b00 && reg_rdata[31:17] == '0)
        else $error("reserved bits nonzero");
    a_gap_write: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_wr |=> min_request_gap_r == $past(reg_wdata[13:0]))
        else $error("gap field not written");
    // select bit follows a control write
    a_sel_write: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_wr |=> gap_timer_start_select_r == $past(reg_wdata[16]))
        else $error("start select not written");
    // first dllp of a burst in idle is passed on
    a_seen_first: assert property (@(posedge clk) disable iff (sys_rst)
        l1_req_rx && state_r == LART_IDLE |=> l1_req_seen)
        else $error("fresh request not passed on");
    // later dllps of a burst are absorbed
    a_burst_absorb: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == LART_PEND |=> !l1_req_seen)
        else $error("burst dllp passed on twice");
    // positive answer closes the burst
    a_accept_idle: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == LART_PEND && l1_accept_tx && !l1_nak_tx |=> state_r == LART_IDLE)
        else $error("accept did not close burst");
    // idle stays idle without a request
    a_idle_hold: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == LART_IDLE && !l1_req_rx |=> state_r == LART_IDLE)
        else $error("idle left without request");
    // select 1: a request in the gap does not end it early
    a_ignore_hold: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == LART_GAP && gap_timer_start_select_r && l1_req_rx && !expire
        && min_request_gap_r != '0 |=> state_r == LART_GAP)
        else $error("ignored request ended gap");
    // gap flag follows the state one cycle later
    a_gap_flag: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == LART_GAP |=> gap_active)
        else $error("gap flag missing");
    // gap flag drops once the gap is over
    a_gap_flag_off: assert property (@(posedge clk) disable iff (sys_rst)
        state_r != LART_GAP |=> !gap_active)
        else $error("gap flag stuck");
    // read data are zero outside the answer cycle
    a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data not cleared");
    // unmapped reads return zero
    a_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr != GAP_CTRL_OFS && reg_addr != GAP_STAT_OFS |=> reg_rdata == '0)
        else $error("unmapped read nonzero");
endmodule
`default_nettype wire

// [pkg/lart_pkg.sv]
// Purpose: shared constants for the L1 request rejection gap timer
// Assumes: 250 MHz core clock, 32-bit register port
// Notes:   one control register, offsets are byte addresses
`default_nettype none
package lart_pkg;
    // register port widths
    localparam int          ADDR_W            = 12;
    localparam int          DATA_W            = 32;
    // control register offset
    localparam logic [11:0] GAP_CTRL_OFS      = 12'h0710;
    // status register offset (timer state readback)
    localparam logic [11:0] GAP_STAT_OFS      = 12'h0714;
    // field layout
    localparam int          GAP_W             = 14;
    localparam int          GAP_LSB           = 0;
    localparam int          START_SEL_BIT     = 16;
    // reset values
    localparam logic [13:0] GAP_RST           = 14'h0947;
    localparam logic        START_SEL_RST     = 1'b1;
    // one gap count is one core clock period
    localparam int          CLK_PERIOD_PS     = 4000;
    // timer states, gray along idle -> pend -> gap
    typedef enum logic [1:0] {
        LART_IDLE = 2'b00,
        LART_PEND = 2'b01,
        LART_GAP  = 2'b11
    } lart_state_t;
endpackage
`default_nettype wire

// [tb/lart_partner.sv]
// Purpose: link partner model sending request bursts
// Assumes: bench pulses go for one clock
// Notes:   two request dllps one cycle apart
`timescale 1ns/10ps
`default_nettype none
module lart_partner (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // bench command, link output
    input  wire logic go,
    output var  logic l1_req_rx
);
    logic [1:0] left_r; // dllps still to send
    // a request is a series of dllps, so the second one tests absorption
    always_ff @(posedge clk) begin
        if (sys_rst) left_r <= 2'b00;
        else if (go) left_r <= 2'b11;
        else left_r <= {1'b0, left_r[1]};
    end
    assign l1_req_rx = left_r[0];
endmodule
`default_nettype wire

// [tb/l1_aspm_rejection_timer_test.sv]
// Purpose: self-checking bench for the gap timer
// Assumes: gap shortened to 8 by register write
// Notes:   counters sample on the falling edge
`timescale 1ns/10ps
`default_nettype none
module l1_aspm_rejection_timer_test;
    import lart_pkg::*;
    logic        clk = 0, sys_rst = 1, wr = 0, rd = 0, go = 0, acc = 0, nak = 0;
    logic [11:0] addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        req_rx, seen, gap;
    int          n_fail = 0, comparisons = 0, cyc = 0, n_gap = 0, n_seen = 0;
    always #2 clk = ~clk;
    lart_partner peer (.clk(clk), .sys_rst(sys_rst), .go(go), .l1_req_rx(req_rx));
    lart_timer dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .l1_req_rx(req_rx), .l1_accept_tx(acc), .l1_nak_tx(nak),
        .l1_req_seen(seen), .gap_active(gap));
    // settled sampling; also cuts a hang short
    always @(negedge clk) begin
        cyc++;
        n_gap += gap;
        n_seen += seen;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d fails %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd32(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    // one-cycle pulse on {go, acc, nak}, then idle cycles
    task automatic fire(input logic [2:0] s, input int idle);
        @(posedge clk);
        {go, acc, nak} <= s;
        @(posedge clk);
        {go, acc, nak} <= 3'b000;
        repeat (idle) @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd32(GAP_CTRL_OFS, 32'h0001_0947);
        rd32(12'h07F0, 32'h0000_0000);
        wr32(GAP_CTRL_OFS, 32'hFFFF_FFFF);
        rd32(GAP_CTRL_OFS, 32'h0001_3FFF);
        $display("register test done");
        n_seen = 0;
        n_gap = 0;
        fire(3'b100, 3);
        rd32(GAP_STAT_OFS, 32'h0000_4000);
        fire(3'b010, 3);
        fire(3'b100, 3);
        chk(32'(n_seen), 32'h0000_0002);
        chk(32'(n_gap), 32'h0000_0000);
        fire(3'b010, 3);
        $display("accept test done");
        // both start modes, a burst lands mid-gap each time
        for (int s = 0; s < 2; s++) begin
            wr32(GAP_CTRL_OFS, {15'h0000, s[0], 16'h0008});
            n_seen = 0;
            n_gap = 0;
            fire(3'b100, 3);
            fire(3'b001, 4);
            fire(3'b100, 30);
            chk(32'(n_seen), 32'h0000_0001);
            chk({30'h0, n_gap > 8, n_gap == 8}, s[0] ? 32'h0000_0001 : 32'h0000_0002);
            fire(3'b100, 3);
            chk(32'(n_seen), 32'h0000_0002);
            fire(3'b010, 3);
            $display("gap test done");
        end
        wrap_up();
    end
endmodule
`default_nettype wire
